// ### qmt_checker.sv
// one read/write checker driving a memory controller user port
`timescale 1ns/100ps
module qmt_checker
#(
	parameter int AW = qmt_pkg::ADDR_WIDTH,
	parameter int DW = qmt_pkg::DATA_WIDTH,
	parameter logic [AW-1:0] LAST_ADDR = {AW{1'b1}}
)
(
	input  wire logic          clock_i,
	input  wire logic          reset_i,
	input  wire logic          start_i,
	input  wire logic          cal_done_i,
	input  wire logic          wait_i,
	input  wire logic          rd_valid_i,
	input  wire logic [DW-1:0] rd_data_i,
	output logic               write_o,
	output logic               read_o,
	output logic [AW-1:0]      addr_o,
	output logic [DW-1:0]      wr_data_o,
	output logic               done_o,
	output logic               pass_o
);

	//------------------------------------------------------------------
	// state
	//------------------------------------------------------------------
	qmt_pkg::qmt_state_type state_r, state_nxt;
	logic [AW-1:0] addr_r, addr_nxt;
	logic [AW:0]   rcnt_r, rcnt_nxt;
	logic [31:0]   wgen_r, wgen_nxt;
	logic [31:0]   rgen_r, rgen_nxt;
	logic          fail_r, fail_nxt;
	logic [DW-1:0] wr_data_r;

	// lfsr step, x^32+x^22+x^2+x^1+1
	function automatic logic [31:0] step(input logic [31:0] v);
		step = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction

	// widen generator to data width
	function automatic logic [DW-1:0] expand(input logic [31:0] v);
		expand = DW'({v[3:0] ^ v[31:28], v});
	endfunction

	// handshake outputs combinational
	assign write_o   = (state_r == qmt_pkg::ST_WRITE);
	assign read_o    = (state_r == qmt_pkg::ST_READ);
	assign addr_o    = addr_r;
	assign wr_data_o = wr_data_r;
	assign done_o    = (state_r == qmt_pkg::ST_DONE);
	assign pass_o    = done_o & ~fail_r; // [R9] [R10]

	//------------------------------------------------------------------
	// next-state logic
	//------------------------------------------------------------------
	always_comb
	begin
		state_nxt = state_r;
		addr_nxt  = addr_r;
		rcnt_nxt  = rcnt_r;
		wgen_nxt  = wgen_r;
		rgen_nxt  = rgen_r;
		fail_nxt  = fail_r;
		// read data is checked and counted only in read or drain state
		if (rd_valid_i && (state_r == qmt_pkg::ST_READ ||
			state_r == qmt_pkg::ST_DRAIN))
		begin
			if (rd_data_i != expand(rgen_r))
				fail_nxt = 1'b1; // [R6] [R13]
			rgen_nxt = step(rgen_r); // [R6]
			rcnt_nxt = rcnt_r + 1'b1;
		end
		unique case (state_r)
			qmt_pkg::ST_IDLE:
			begin
				if (start_i)
					state_nxt = qmt_pkg::ST_CAL;
			end
			qmt_pkg::ST_CAL:
			begin
				addr_nxt = '0;
				rcnt_nxt = '0;
				wgen_nxt = qmt_pkg::SEED;
				rgen_nxt = qmt_pkg::SEED;
				fail_nxt = 1'b0;
				if (cal_done_i)
					state_nxt = qmt_pkg::ST_WRITE; // [R14]
			end
			qmt_pkg::ST_WRITE:
			begin
				// hold request while port waits
				if (!wait_i) // [R14]
				begin
					wgen_nxt = step(wgen_r);
					addr_nxt = addr_r + 1'b1;
					if (addr_r == LAST_ADDR)
						state_nxt = qmt_pkg::ST_READ; // [R5]
				end
			end
			qmt_pkg::ST_READ:
			begin
				if (!wait_i) // [R14]
				begin
					addr_nxt = addr_r + 1'b1;
					if (addr_r == LAST_ADDR)
						state_nxt = qmt_pkg::ST_DRAIN; // [R4]
				end
			end
			qmt_pkg::ST_DRAIN:
			begin
				// every issued read must return before judging
				if (rcnt_nxt == {1'b0, LAST_ADDR} + 1'b1)
					state_nxt = qmt_pkg::ST_DONE;
			end
			qmt_pkg::ST_DONE:
			begin
				state_nxt = qmt_pkg::ST_DONE; // [R13]
			end
			default:
			begin
				state_nxt = qmt_pkg::ST_IDLE;
			end
		endcase
	end

	//------------------------------------------------------------------
	// registers
	//------------------------------------------------------------------
	always_ff @(posedge clock_i)
	begin
		if (reset_i)
		begin
			state_r   <= qmt_pkg::ST_IDLE;
			addr_r    <= '0;
			rcnt_r    <= '0;
			wgen_r    <= qmt_pkg::SEED;
			rgen_r    <= qmt_pkg::SEED;
			fail_r    <= 1'b0;
			wr_data_r <= '0;
		end
		else
		begin
			state_r   <= state_nxt;
			addr_r    <= addr_nxt;
			rcnt_r    <= rcnt_nxt;
			wgen_r    <= wgen_nxt;
			rgen_r    <= rgen_nxt;
			fail_r    <= fail_nxt;
			wr_data_r <= expand(wgen_nxt);
		end
	end

endmodule

// ### qmt_pkg.sv
// package of constants for the quad memory read/write checker
//----------------------------------------------------------------------
// Function
// (R1) memory 550 MHz, checkers on 275 MHz clock
// (R2) address range covers whole 144 Mbit memory
// (R3) reference clocks reprogrammed 300 to 275 MHz first
// (R4) write and read whole space via user port
// (R5) full write pass before read pass
// (R6) regenerate write sequence, compare each word
// (R7) all checker control from restart pushbutton
// (R8) lamps off while pushbutton held low
// (R9) after release run test, lamp lights on pass
// (R10) dark lamp after release means failure
// (R11) lamps a..d report memories a..d
// (R12) each press and release reruns full test
// (R13) result held until next press; mismatch fails
// (R14) wait for calibration, obey wait, read-valid
//----------------------------------------------------------------------
package qmt_pkg;

	// clock figures
	localparam int MEM_CLOCK_MHZ      = 550;
	localparam int SYS_CLOCK_MHZ      = 275;
	localparam int REFCLK_DEFAULT_MHZ = 300;

	// memory geometry: 144 Mbit as 36-bit words
	localparam longint MEM_BITS   = 64'd150994944;
	localparam int     DATA_WIDTH = 36;
	localparam int     WORD_COUNT = 4194304;
	localparam int     ADDR_WIDTH = 22;

	// generator seed, nonzero lfsr state
	localparam logic [31:0] SEED = 32'h1234_5678;

	// checker sequence
	typedef enum logic [2:0]
	{
		ST_IDLE  = 3'b000,
		ST_CAL   = 3'b001,
		ST_WRITE = 3'b010,
		ST_READ  = 3'b011,
		ST_DRAIN = 3'b100,
		ST_DONE  = 3'b101
	} qmt_state_type;

endpackage

// ### qmt_top.sv
// four memory checkers, pushbutton restart and result lamps
`timescale 1ns/100ps
module qmt_top
#(
	parameter int AW = qmt_pkg::ADDR_WIDTH,
	parameter int DW = qmt_pkg::DATA_WIDTH,
	parameter logic [AW-1:0] LAST_ADDR = {AW{1'b1}}
)
(
	input  wire logic            clock_i,
	input  wire logic            reset_i,
	input  wire logic            restart_n_i,
	input  wire logic            refclk_ready_i,
	input  wire logic [3:0]      cal_done_i,
	input  wire logic [3:0]      wait_i,
	input  wire logic [3:0]      rd_valid_i,
	input  wire logic [4*DW-1:0] rd_data_i,
	output logic [3:0]           write_o,
	output logic [3:0]           read_o,
	output logic [4*AW-1:0]      addr_o,
	output logic [4*DW-1:0]      wr_data_o,
	output logic                 result_lamp_a_o,
	output logic                 result_lamp_b_o,
	output logic                 result_lamp_c_o,
	output logic                 result_lamp_d_o
);

	//------------------------------------------------------------------
	// restart control
	//------------------------------------------------------------------
	logic       held_r, held_nxt;
	logic       start_r, start_nxt;
	logic       run_reset;
	logic [3:0] pass;
	logic [3:0] lamp_r, lamp_nxt;

	// checkers held in reset while button down; release starts them.
	// start waits for refclk reprogramming so controllers are valid
	always_comb
	begin
		held_nxt  = ~restart_n_i; // [R7]
		start_nxt = refclk_ready_i & ~held_r; // [R3] [R12]
		lamp_nxt  = held_r ? 4'h0 : pass; // [R8] [R9]
	end

	assign run_reset = reset_i | held_r; // [R7] [R12]

	always_ff @(posedge clock_i)
	begin
		if (reset_i)
		begin
			held_r  <= 1'b1;
			start_r <= 1'b0;
			lamp_r  <= 4'h0;
		end
		else
		begin
			held_r  <= held_nxt;
			start_r <= start_nxt;
			lamp_r  <= lamp_nxt;
		end
	end

	// lamp a..d map to memory a..d
	assign result_lamp_a_o = lamp_r[0]; // [R11]
	assign result_lamp_b_o = lamp_r[1];
	assign result_lamp_c_o = lamp_r[2];
	assign result_lamp_d_o = lamp_r[3];

	//------------------------------------------------------------------
	// checkers, one per memory, all on the 275 MHz clock
	//------------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < 4; g++)
		begin : gen_chk
			qmt_checker
			#(
				.AW        (AW),
				.DW        (DW),
				.LAST_ADDR (LAST_ADDR)
			)
			u_chk
			(
				.clock_i    (clock_i), // [R1]
				.reset_i    (run_reset),
				.start_i    (start_r),
				.cal_done_i (cal_done_i[g]),
				.wait_i     (wait_i[g]),
				.rd_valid_i (rd_valid_i[g]),
				.rd_data_i  (rd_data_i[g*DW +: DW]),
				.write_o    (write_o[g]),
				.read_o     (read_o[g]),
				.addr_o     (addr_o[g*AW +: AW]), // [R2] [R4]
				.wr_data_o  (wr_data_o[g*DW +: DW]),
				.done_o     (),
				.pass_o     (pass[g])
			);
		end
	endgenerate

endmodule

// ### qmt_rw_monitor.sv
// port assertions for the quad memory checker
`timescale 1ns/100ps
module qmt_rw_monitor
#(
	parameter int AW = 22,
	parameter logic [AW-1:0] LAST_ADDR = {AW{1'b1}}
)
(
	input wire logic            clock_i,
	input wire logic            reset_i,
	input wire logic            restart_n_i,
	input wire logic [3:0]      cal_done_i,
	input wire logic [3:0]      wait_i,
	input wire logic [3:0]      write_o,
	input wire logic [3:0]      read_o,
	input wire logic [4*AW-1:0] addr_o,
	input wire logic            result_lamp_a_o,
	input wire logic            result_lamp_b_o,
	input wire logic            result_lamp_c_o,
	input wire logic            result_lamp_d_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (reset_i);
	// lamps in memory order
	wire logic [3:0] lamp = {result_lamp_d_o, result_lamp_c_o,
		result_lamp_b_o, result_lamp_a_o};

	// writes taken on memory a since the button was last pressed
	logic [AW:0] wr_taken;
	always_ff @(posedge clock_i)
	begin
		if (reset_i || !restart_n_i)
			wr_taken <= '0;
		else if (write_o[0] && !wait_i[0])
			wr_taken <= wr_taken + 1'b1;
	end

	// button passes a flop, then the lamp flop: dark from third low sample
	AST_LAMP_DARK: assert property (!restart_n_i ##1 !restart_n_i
		##1 !restart_n_i |-> lamp == 4'h0) else $error("lamp lit while held");
	AST_HELD_IDLE: assert property (!restart_n_i ##1 !restart_n_i
		##1 !restart_n_i |-> (write_o | read_o) == 4'h0)
		else $error("request while held");
	AST_WRITES_FIRST: assert property ($rose(read_o[0])
		|-> wr_taken == {1'b0, LAST_ADDR} + 1'b1)
		else $error("read pass before full write pass");
	AST_CAL_GATE: assert property (((write_o | read_o) & ~cal_done_i) == 4'h0)
		else $error("request before calibration");
	AST_ONE_KIND: assert property ((write_o & read_o) == 4'h0)
		else $error("read and write together");
	AST_WR_HOLD: assert property (restart_n_i && write_o[0] && wait_i[0]
		|=> write_o[0] && $stable(addr_o[AW-1:0])) else $error("write dropped");
	AST_RD_HOLD: assert property (restart_n_i && read_o[1] && wait_i[1]
		|=> read_o[1] && $stable(addr_o[AW+:AW])) else $error("read dropped");
	AST_ADDR_STEP: assert property (restart_n_i && write_o[2] && !wait_i[2]
		&& addr_o[2*AW+:AW] != LAST_ADDR
		|=> addr_o[2*AW+:AW] == $past(addr_o[2*AW+:AW]) + 1'b1)
		else $error("address skipped");
	AST_READ_ZERO: assert property ($rose(read_o[3])
		|-> addr_o[3*AW+:AW] == {AW{1'b0}}) else $error("read pass not at 0");
	AST_LAMP_KEEP: assert property (restart_n_i && result_lamp_b_o
		|=> result_lamp_b_o) else $error("lamp dropped");
endmodule

// ### qmt_mem_model.sv
// far-side model of four controller user ports
`timescale 1ns/100ps
module qmt_mem_model
#(
	parameter int AW = 4,
	parameter int DW = 36
)
(
	input  wire logic            clock_i,
	input  wire logic            stall_i,
	input  wire logic [3:0]      corrupt_i,
	input  wire logic [3:0]      write_i,
	input  wire logic [3:0]      read_i,
	input  wire logic [4*AW-1:0] addr_i,
	input  wire logic [4*DW-1:0] wr_data_i,
	output logic [3:0]           wait_o = 4'h0,
	output logic [3:0]           rd_valid_o = 4'h0,
	output logic [4*DW-1:0]      rd_data_o = '0
);
	logic [DW-1:0] mem [4][2**AW];
	// store writes, answer reads next cycle; stale data is scrambled
	always @(posedge clock_i)
	begin
		for (int g = 0; g < 4; g++)
		begin
			rd_valid_o[g] <= 1'b0;
			rd_data_o[g*DW+:DW] <= ~rd_data_o[g*DW+:DW];
			if (write_i[g] && !wait_o[g])
				mem[g][addr_i[g*AW+:AW]] <= wr_data_i[g*DW+:DW];
			if (read_i[g] && !wait_o[g])
			begin
				rd_valid_o[g] <= 1'b1;
				rd_data_o[g*DW+:DW] <= mem[g][addr_i[g*AW+:AW]]
					^ DW'(corrupt_i[g]);
			end
			wait_o[g] <= stall_i & 1'($urandom_range(1, 0));
		end
	end
endmodule

// ### test_qmt_top.sv
// bench for the quad memory checker top
`timescale 1ns/100ps
module test_qmt_top;
	localparam int AW = 4;
	localparam int DW = 36;
	logic            clock_i = 0, reset_i = 1, restart_n_i = 1, ready = 0;
	logic            stall = 0;
	logic [3:0]      cal = 0, bad = 0, wr, rd, wt, vld;
	wire logic [3:0] lamp;
	logic [4*AW-1:0] addr;
	logic [4*DW-1:0] wd, rdd;
	logic [3:0]      q[$];
	int              failures = 0, checks = 0, cyc = 0;
	event            got;

	qmt_top #(.AW(AW), .DW(DW), .LAST_ADDR(4'hf)) dut_u (.clock_i(clock_i),
		.reset_i(reset_i), .restart_n_i(restart_n_i), .refclk_ready_i(ready),
		.cal_done_i(cal), .wait_i(wt), .rd_valid_i(vld), .rd_data_i(rdd),
		.write_o(wr), .read_o(rd), .addr_o(addr), .wr_data_o(wd),
		.result_lamp_a_o(lamp[0]), .result_lamp_b_o(lamp[1]),
		.result_lamp_c_o(lamp[2]), .result_lamp_d_o(lamp[3]));
	qmt_mem_model #(.AW(AW), .DW(DW)) mem_u (.clock_i(clock_i),
		.stall_i(stall), .corrupt_i(bad), .write_i(wr), .read_i(rd),
		.addr_i(addr), .wr_data_i(wd), .wait_o(wt), .rd_valid_o(vld),
		.rd_data_o(rdd));

	initial forever #10 clock_i = ~clock_i;

	// press, release, then wait for the lamps to settle
	task automatic run(input logic [3:0] mask);
		int n;
		bad = mask;
		restart_n_i = 0;
		repeat (4) @(negedge clock_i);
		cal = 4'h0;
		q.push_back(4'h0);
		-> got;
		restart_n_i = 1;
		repeat (30) @(negedge clock_i);
		cal = 4'hf;
		for (n = 0; n < 900 && lamp !== ~mask; n++)
			@(negedge clock_i);
		repeat (5) @(negedge clock_i);
		q.push_back(~mask);
		-> got;
	endtask

	task automatic conclude();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// one compare for the lamp result
	task automatic compare_lamp(input logic [3:0] expv);
		checks++;
		if (lamp !== expv)
		begin
			failures++;
			$display("[ERR] %0t exp %h got %h", $time, expv, lamp);
		end
	endtask

	// watcher: oldest note against the lamps
	always @(got)
		compare_lamp(q.pop_front());

	// hang guard, well above three runs
	always @(posedge clock_i)
	begin
		cyc++;
		if (cyc == 8000)
		begin
			failures++;
			conclude();
		end
	end

	initial
	begin
		void'($urandom(58276));
		repeat (12) @(negedge clock_i);
		reset_i = 0;
		ready = 1;
		stall = 1;
		run(4'h0);
		run(4'($urandom_range(14, 1)));
		stall = 0;
		run(4'h0);
		// let the watcher take the last note before the verdict
		repeat (2) @(negedge clock_i);
		conclude();
	end
endmodule

bind qmt_top qmt_rw_monitor #(.AW(AW), .LAST_ADDR(LAST_ADDR)) mon_u (.clock_i,
	.reset_i, .restart_n_i, .cal_done_i, .wait_i, .write_o, .read_o, .addr_o,
	.result_lamp_a_o, .result_lamp_b_o, .result_lamp_c_o, .result_lamp_d_o);
